//--- hdl/timer_pkg.sv
// Shared constants for the twelve-bit auto-reload pulse timer
`default_nettype none
package timer_pkg;
	localparam int CNT_W = 12;
	localparam int HI_W = CNT_W - 8;
	localparam int ADDR_W = 8;
	localparam int IDX_W = 6;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hfff;
	localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int SLOW_DIV = 32;
	localparam int SLOW_DIV_W = $clog2(SLOW_DIV);
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_TIMER_CTRL_STATUS = 6'h0d;
	localparam logic [IDX_W-1:0] IDX_COUNTER_HIGH = 6'h0e;
	localparam logic [IDX_W-1:0] IDX_COUNTER_LOW = 6'h0f;
	localparam logic [IDX_W-1:0] IDX_RELOAD_HIGH = 6'h10;
	localparam logic [IDX_W-1:0] IDX_RELOAD_LOW = 6'h11;
	localparam logic [IDX_W-1:0] IDX_PULSE_OUTPUT_CONTROL = 6'h12;
	localparam logic [IDX_W-1:0] IDX_PULSE_CHANNEL_STATUS = 6'h13;
	localparam logic [IDX_W-1:0] IDX_DUTY_HIGH = 6'h17;
	localparam logic [IDX_W-1:0] IDX_DUTY_LOW = 6'h18;
	// timer_ctrl_status fields
	localparam int BIT_CMP_IRQ_EN = 0;
	localparam int BIT_OVF_IRQ_EN = 1;
	localparam int BIT_OVF_FLAG = 2;
	localparam int BIT_CLK_SEL_LO = 3;
	localparam int BIT_CLK_SEL_HI = 4;
	// pulse_output_control and pulse_channel_status fields
	localparam int BIT_PWM_OUT_EN = 0;
	localparam int BIT_CMP_FLAG = 0;
	localparam int BIT_POLARITY = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		CLK_OFF = 2'b00,
		CLK_LITE_TICK = 2'b01,
		CLK_CPU = 2'b10,
		CLK_RESERVED = 2'b11
	} clk_sel_t;
endpackage
`default_nettype wire

//--- hdl/byte_pair_reg.sv
// Twelve-bit value written as a high and a low byte
`default_nettype none
module byte_pair_reg #(
	parameter int W = 12
) (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic wr_hi_i,
	input wire logic wr_lo_i,
	input wire logic [7:0] data_i,
	output logic [W-1:0] value_o
);
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			value_o <= '0;
		end else if (wr_hi_i) begin
			// Upper bits above W are reserved and dropped
			value_o[W-1:8] <= data_i[W-9:0];
		end else if (wr_lo_i) begin
			value_o[7:0] <= data_i;
		end
	end
endmodule
`default_nettype wire

//--- hdl/count_enable_gen.sv
// Counter clock selection, low-power gating and slow-mode divider
`default_nettype none
module count_enable_gen
	import timer_pkg::*;
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic [1:0] clock_select_i,
	input wire logic lite_timer_tick_i,
	input wire logic slow_mode_i,
	input wire logic halt_mode_i,
	input wire logic active_halt_i,
	input wire logic overflow_irq_enable_i,
	output logic count_en_o
);
	logic src;
	logic gate;
	logic [SLOW_DIV_W-1:0] div;

	always_comb begin
		case (clock_select_i)
			CLK_LITE_TICK: src = lite_timer_tick_i;
			CLK_CPU: src = 1'b1;
			default: src = 1'b0;
		endcase
	end

	// Only the tick source with the overflow interrupt keeps counting in active-halt
	assign gate = !halt_mode_i && (!active_halt_i ||
		(clock_select_i == CLK_LITE_TICK && overflow_irq_enable_i)); // RULE20

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div <= '0;
		end else if (src && gate && slow_mode_i) begin
			div <= div + 1'b1; // RULE20
		end
	end

	assign count_en_o = src && gate && (!slow_mode_i || &div); // RULE16
endmodule
`default_nettype wire

//--- hdl/autoreload_timer_pwm.sv
// Twelve-bit auto-reload timer with one pulse output and AXI4-Lite registers
// Operation
// RULE1: Pulse period is 4096 minus reload_value counter clock cycles.
// RULE2: Software keeps reload_value at or below 4094.
// RULE3: Counter starts from zero after reset once a clock is selected.
// RULE4: Overflow reloads counter, loads shadow duty, sets pulse high.
// RULE5: Overflow is counter going from FFFh to reload_value; sets overflow_flag.
// RULE6: Pulse mode: counter equal to active duty drives pulse low.
// RULE7: Software sets duty above reload_value to get a toggling pulse.
// RULE8: Polarity bit inverts the pulse output.
// RULE9: pwm_out_enable hands the pin to the push-pull pulse output.
// RULE10: Duty high byte first; its write suspends compare until low byte.
// RULE11: Every overflow copies duty registers into shadow, even half-written.
// RULE12: Compare mode compares against duty registers at once, no pulse.
// RULE13: Counter equal to compared duty sets compare_flag, interrupt if enabled.
// RULE14: Compare matching only for nonzero duty value.
// RULE15: Software updates duty just after, or near, an overflow.
// RULE16: clock_select picks off, lite-timer tick, CPU clock, or reserved.
// RULE17: Reading control/status clears overflow_flag; flag lasts one counter cycle.
// RULE18: overflow_flag with overflow_irq_enable raises its own interrupt.
// RULE19: Both interrupts wake from wait; only overflow, tick-clocked, from active-halt.
// RULE20: Halt stops counter; active-halt unless tick and irq; slow divides 32.
// RULE21: Counter read as two unlatched bytes.
// RULE22: Reload is twelve bits, upper four bits read zero.
// RULE23: Reading pulse-channel status clears compare_flag.
// RULE24: Polarity bit: 0 normal, 1 inverted, cleared by reset.
// RULE25: All registers reset to zero: clock off, output disabled.
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module autoreload_timer_pwm
	import timer_pkg::*;
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic [timer_pkg::ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [timer_pkg::ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	input wire logic lite_timer_tick_i,
	input wire logic slow_mode_i,
	input wire logic halt_mode_i,
	input wire logic active_halt_i,
	input wire logic gpio_out_i,
	input wire logic gpio_oe_n_i,
	output logic pin_out_o,
	output logic pin_oe_n_o,
	output logic overflow_irq_o,
	output logic compare_irq_o,
	output logic wake_wait_o,
	output logic wake_active_halt_o
);
	import timer_pkg::*;
	default clocking sva_clk @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	logic [1:0] clock_select;
	logic overflow_flag;
	logic overflow_irq_enable;
	logic compare_irq_enable;
	logic pwm_out_enable;
	logic output_polarity;
	logic compare_flag;
	logic [CNT_W-1:0] counter_value;
	logic [CNT_W-1:0] reload_value;
	logic [CNT_W-1:0] duty_value;
	logic [CNT_W-1:0] shadow_duty;
	logic duty_lock;
	logic pulse_raw;
	logic count_en;
	logic ovf_evt;
	logic cmp_hit;
	logic [CNT_W-1:0] next_counter;
	logic [CNT_W-1:0] cmp_value;

	// Bus slave state
	logic aw_held;
	logic w_held;
	logic [IDX_W-1:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane0;
	logic wr_fire;
	logic rd_fire;
	logic [IDX_W-1:0] rd_idx;
	logic wr_en;
	logic wr_map_ok;
	logic [7:0] rd_byte;
	logic rd_map_ok;
	logic rd_ctrl;
	logic rd_status;

	assign awready_o = !aw_held && !bvalid_o;
	assign wready_o = !w_held && !bvalid_o;
	assign wr_fire = aw_held && w_held && !bvalid_o;
	assign arready_o = !rvalid_o;
	assign rd_fire = arvalid_i && arready_o;
	assign rd_idx = araddr_i[ADDR_W-1:2];

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aw_held <= 1'b0;
			aw_idx <= '0;
		end else if (awvalid_i && awready_o) begin
			aw_held <= 1'b1;
			aw_idx <= awaddr_i[ADDR_W-1:2];
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			w_held <= 1'b0;
			w_byte <= REG_RESET;
			w_lane0 <= 1'b0;
		end else if (wvalid_i && wready_o) begin
			w_held <= 1'b1;
			w_byte <= wdata_i[7:0];
			w_lane0 <= wstrb_i[0];
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end
	end

	always_comb begin
		case (aw_idx)
			IDX_TIMER_CTRL_STATUS, IDX_RELOAD_HIGH, IDX_RELOAD_LOW,
			IDX_PULSE_OUTPUT_CONTROL, IDX_PULSE_CHANNEL_STATUS,
			IDX_DUTY_HIGH, IDX_DUTY_LOW: wr_map_ok = 1'b1;
			// Counter bytes are read-only, so writes there are refused
			default: wr_map_ok = 1'b0;
		endcase
	end

	// Writes without byte lane 0 are accepted but change nothing
	assign wr_en = wr_fire && wr_map_ok && w_lane0;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_o <= 1'b1;
			bresp_o <= wr_map_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	always_comb begin
		rd_map_ok = 1'b1;
		case (rd_idx)
			IDX_TIMER_CTRL_STATUS: rd_byte = {3'h0, clock_select, overflow_flag,
				overflow_irq_enable, compare_irq_enable};
			IDX_COUNTER_HIGH: rd_byte = {{(8-HI_W){1'b0}}, counter_value[CNT_W-1:8]}; // RULE21
			IDX_COUNTER_LOW: rd_byte = counter_value[7:0]; // RULE21
			IDX_RELOAD_HIGH: rd_byte = {{(8-HI_W){1'b0}}, reload_value[CNT_W-1:8]}; // RULE22
			IDX_RELOAD_LOW: rd_byte = reload_value[7:0];
			IDX_PULSE_OUTPUT_CONTROL: rd_byte = {7'h00, pwm_out_enable};
			IDX_PULSE_CHANNEL_STATUS: rd_byte = {6'h00, output_polarity, compare_flag};
			IDX_DUTY_HIGH: rd_byte = {{(8-HI_W){1'b0}}, duty_value[CNT_W-1:8]};
			IDX_DUTY_LOW: rd_byte = duty_value[7:0];
			default: begin
				rd_byte = REG_RESET;
				rd_map_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid_o <= 1'b0;
			rdata_o <= '0;
			rresp_o <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_o <= 1'b1;
			rdata_o <= {24'h000000, rd_byte};
			rresp_o <= rd_map_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rready_i) begin
			rvalid_o <= 1'b0;
		end
	end

	// Read side effects happen when the address is taken
	assign rd_ctrl = rd_fire && rd_idx == IDX_TIMER_CTRL_STATUS;
	assign rd_status = rd_fire && rd_idx == IDX_PULSE_CHANNEL_STATUS;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			clock_select <= CLK_OFF; // RULE25
			overflow_irq_enable <= 1'b0;
			compare_irq_enable <= 1'b0;
		end else if (wr_en && aw_idx == IDX_TIMER_CTRL_STATUS) begin
			clock_select <= w_byte[BIT_CLK_SEL_HI:BIT_CLK_SEL_LO]; // RULE16
			overflow_irq_enable <= w_byte[BIT_OVF_IRQ_EN];
			compare_irq_enable <= w_byte[BIT_CMP_IRQ_EN];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pwm_out_enable <= 1'b0; // RULE25
		end else if (wr_en && aw_idx == IDX_PULSE_OUTPUT_CONTROL) begin
			pwm_out_enable <= w_byte[BIT_PWM_OUT_EN];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			output_polarity <= 1'b0; // RULE24
		end else if (wr_en && aw_idx == IDX_PULSE_CHANNEL_STATUS) begin
			output_polarity <= w_byte[BIT_POLARITY]; // RULE24
		end
	end

	byte_pair_reg #(
		.W(CNT_W)
	) u_reload (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.wr_hi_i(wr_en && aw_idx == IDX_RELOAD_HIGH),
		.wr_lo_i(wr_en && aw_idx == IDX_RELOAD_LOW),
		.data_i(w_byte),
		.value_o(reload_value)
	);

	byte_pair_reg #(
		.W(CNT_W)
	) u_duty (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.wr_hi_i(wr_en && aw_idx == IDX_DUTY_HIGH),
		.wr_lo_i(wr_en && aw_idx == IDX_DUTY_LOW),
		.data_i(w_byte),
		.value_o(duty_value)
	);

	count_enable_gen u_count_en (
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.clock_select_i(clock_select),
		.lite_timer_tick_i(lite_timer_tick_i),
		.slow_mode_i(slow_mode_i),
		.halt_mode_i(halt_mode_i),
		.active_halt_i(active_halt_i),
		.overflow_irq_enable_i(overflow_irq_enable),
		.count_en_o(count_en)
	);

	// Counter
	assign ovf_evt = count_en && counter_value == CNT_MAX; // RULE5
	assign next_counter = ovf_evt ? reload_value : counter_value + 1'b1; // RULE1

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			counter_value <= CNT_RESET; // RULE3
		end else if (count_en) begin
			counter_value <= next_counter; // RULE4
		end
	end

	// Flag lasts one counter cycle; a new overflow beats any clear
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			overflow_flag <= 1'b0;
		end else if (ovf_evt) begin
			overflow_flag <= 1'b1; // RULE5
		end else if (rd_ctrl || count_en) begin
			overflow_flag <= 1'b0; // RULE17
		end
	end

	// Compare is suspended between the duty high and low byte writes
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			duty_lock <= 1'b0;
		end else if (wr_en && aw_idx == IDX_DUTY_HIGH) begin
			duty_lock <= 1'b1; // RULE10
		end else if (wr_en && aw_idx == IDX_DUTY_LOW) begin
			duty_lock <= 1'b0; // RULE10
		end
	end

	// Copied even mid-update, so it may pair a new high byte with an old low byte
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shadow_duty <= CNT_RESET;
		end else if (ovf_evt) begin
			shadow_duty <= duty_value; // RULE11
		end
	end

	assign cmp_value = pwm_out_enable ? shadow_duty : duty_value; // RULE12
	assign cmp_hit = count_en && !duty_lock && cmp_value != CNT_RESET &&
		next_counter == cmp_value; // RULE14

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			compare_flag <= 1'b0;
		end else if (cmp_hit) begin
			compare_flag <= 1'b1; // RULE13
		end else if (rd_status) begin
			compare_flag <= 1'b0; // RULE23
		end
	end

	// Match wins over overflow so duty equal to reload gives a flat output
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pulse_raw <= 1'b0;
		end else if (cmp_hit && pwm_out_enable) begin
			pulse_raw <= 1'b0; // RULE6
		end else if (ovf_evt) begin
			pulse_raw <= 1'b1; // RULE4
		end
	end

	// Pin is registered, so it lags the pulse by one clock
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_out_o <= 1'b0;
			pin_oe_n_o <= 1'b1;
		end else if (pwm_out_enable) begin
			pin_out_o <= pulse_raw ^ output_polarity; // RULE8
			pin_oe_n_o <= 1'b0; // RULE9
		end else begin
			pin_out_o <= gpio_out_i; // RULE9
			pin_oe_n_o <= gpio_oe_n_i;
		end
	end

	assign overflow_irq_o = overflow_flag && overflow_irq_enable; // RULE18
	assign compare_irq_o = compare_flag && compare_irq_enable; // RULE13
	assign wake_wait_o = overflow_irq_o || compare_irq_o; // RULE19
	assign wake_active_halt_o = overflow_irq_o && clock_select == CLK_LITE_TICK; // RULE19
	AST_RELOAD: assert property (ovf_evt |=> counter_value == $past(reload_value)) // RULE4
		else $error("Counter did not reload on overflow");
	AST_INCREMENT: assert property (count_en && counter_value != CNT_MAX // RULE1
		|=> counter_value == $past(counter_value) + 12'h001) else $error("Counter did not step by one");
	AST_OVF_SET: assert property (ovf_evt |=> overflow_flag) // RULE5
		else $error("Overflow flag not set");
	AST_OVF_CLEAR: assert property (rd_ctrl && !ovf_evt |=> !overflow_flag) // RULE17
		else $error("Overflow flag survived a control read");
	AST_PULSE_HIGH: assert property (ovf_evt && !cmp_hit ##1 pwm_out_enable // RULE4
		|-> pulse_raw ##1 pin_out_o != $past(output_polarity)) else $error("Pulse not high after overflow");
	AST_CLOCK_OFF: assert property (clock_select == CLK_OFF || clock_select == CLK_RESERVED || halt_mode_i // RULE16
		|=> $stable(counter_value)) else $error("Counter moved with no counter clock");
	AST_LOCK: assert property (duty_lock |-> !cmp_hit) // RULE10
		else $error("Compare ran while duty update pending");
	AST_CMP_FLAG: assert property (count_en && !duty_lock && !pwm_out_enable && duty_value != 12'h000 // RULE13
		&& next_counter == duty_value |=> compare_flag) else $error("Compare flag missed a match");
	AST_SHADOW: assert property (ovf_evt |=> shadow_duty == $past(duty_value)) // RULE11
		else $error("Shadow duty not loaded on overflow");
	AST_PIN_DRIVE: assert property (pwm_out_enable |=> !pin_oe_n_o // RULE9
		&& pin_out_o == $past(pulse_raw ^ output_polarity)) else $error("Pin not carrying the pulse");
	AST_ACT_HALT: assert property (active_halt_i && !overflow_irq_enable |-> !count_en) // RULE20
		else $error("Counter ran in active-halt");
endmodule
`default_nettype wire

//--- verif/pulse_load.sv
// External load on the pulse pin: measures period and high time
`default_nettype none
module pulse_load (
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic pin_out_i,
	input wire logic pin_oe_n_i,
	output logic [15:0] period_o,
	output logic [15:0] high_o,
	output logic [7:0] edges_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic level;
	logic prev;
	logic [15:0] cnt;
	logic [15:0] hcnt;
	// Released pin sits on its pull-down
	assign level = pin_oe_n_i ? 1'b0 : pin_out_i;
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev <= 1'b0;
			cnt <= 16'h0;
			hcnt <= 16'h0;
			period_o <= 16'h0;
			high_o <= 16'h0;
			edges_o <= 8'h0;
		end else begin
			prev <= level;
			cnt <= cnt + 16'h1;
			if (level)
				hcnt <= hcnt + 16'h1;
			if (level && !prev) begin
				period_o <= cnt;
				high_o <= hcnt;
				cnt <= 16'h1;
				hcnt <= 16'h1;
				edges_o <= edges_o + 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

//--- verif/autoreload_timer_pwm_tb.sv
// Self-checking bench for the auto-reload pulse timer
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module autoreload_timer_pwm_tb;
	import timer_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic wr;
		logic [IDX_W-1:0] idx;
		logic [7:0] wd;
		logic [1:0] wresp;
		logic [7:0] rd;
		logic [1:0] rresp;
	} row_t;
	localparam logic [11:0] RLD = 12'hff0;
	localparam logic [11:0] DUTY = 12'hffc;
	localparam logic [15:0] PER = 16'(4096 - int'(RLD));
	localparam logic [15:0] HIGH = 16'(DUTY - RLD);
	logic clock = 1'b0, arst_n = 1'b0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe_n;
	logic overflow_irq, compare_irq, wake_wait, wake_active_halt;
	logic [1:0] bresp, rresp, last_resp;
	logic [31:0] rdata, last_rd;
	logic tick = 1'b0, halt = 1'b0, gpio_out = 1'b1, gpio_oe_n = 1'b1, slow = 1'b0, ahalt = 1'b0;
	logic [1:0] irqs;
	logic [15:0] period, high;
	logic [7:0] edges;
	int tick_gap = 0, tick_cnt = 0, fail_count = 0, compares = 0, hits;
	logic [31:0] v1;
	row_t rows[9] = '{
		'{1'b0, IDX_TIMER_CTRL_STATUS, 8'h00, RESP_OKAY, REG_RESET, RESP_OKAY},
		'{1'b0, IDX_PULSE_OUTPUT_CONTROL, 8'h00, RESP_OKAY, REG_RESET, RESP_OKAY},
		'{1'b1, IDX_RELOAD_HIGH, 8'hff, RESP_OKAY, 8'h0f, RESP_OKAY},
		'{1'b1, IDX_RELOAD_LOW, RLD[7:0], RESP_OKAY, RLD[7:0], RESP_OKAY},
		'{1'b1, IDX_DUTY_HIGH, {4'h0, DUTY[11:8]}, RESP_OKAY, {4'h0, DUTY[11:8]}, RESP_OKAY},
		'{1'b1, IDX_DUTY_LOW, DUTY[7:0], RESP_OKAY, DUTY[7:0], RESP_OKAY},
		'{1'b1, IDX_PULSE_CHANNEL_STATUS, 8'h01, RESP_OKAY, 8'h00, RESP_OKAY},
		'{1'b1, IDX_COUNTER_LOW, 8'h55, RESP_SLVERR, CNT_RESET[7:0], RESP_OKAY},
		'{1'b1, 6'h3f, 8'h12, RESP_SLVERR, 8'h00, RESP_SLVERR}
	};
	assign irqs = {compare_irq, overflow_irq};
	always #50 clock = ~clock;
	// Lite-timer tick: one-cycle pulse every tick_gap clocks, none when zero
	always @(posedge clock) begin
		tick_cnt <= (tick_cnt + 1 >= tick_gap) ? 0 : tick_cnt + 1;
		tick <= (tick_gap > 0) && (tick_cnt == tick_gap - 1);
	end
	autoreload_timer_pwm dut (.clock_i(clock), .arst_n_i(arst_n), .awaddr_i(awaddr), .awvalid_i(awvalid),
		.awready_o(awready), .wdata_i(wdata), .wstrb_i(4'h1), .wvalid_i(wvalid), .wready_o(wready),
		.bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
		.lite_timer_tick_i(tick), .slow_mode_i(slow), .halt_mode_i(halt), .active_halt_i(ahalt),
		.gpio_out_i(gpio_out), .gpio_oe_n_i(gpio_oe_n), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n),
		.overflow_irq_o(overflow_irq), .compare_irq_o(compare_irq), .wake_wait_o(wake_wait),
		.wake_active_halt_o(wake_active_halt));
	pulse_load load (.clock_i(clock), .arst_n_i(arst_n), .pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n),
		.period_o(period), .high_o(high), .edges_o(edges));
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic guard(input int n, input int lim);
		if (n > lim) begin
			fail_count++;
			$display("unexpected timeout at %0t: waited %h limit %h", $time, n, lim);
			wrap_up();
		end
	endtask
	task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
		int n;
		logic aw_ok, w_ok;
		n = 0;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clock);
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clock);
			if (awvalid && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
			guard(++n, 50);
		end
		do begin
			@(posedge clock);
			guard(++n, 50);
		end while (bvalid !== 1'b1);
		last_resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [IDX_W-1:0] i);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			guard(++n, 50);
		end while (arready !== 1'b1);
		arvalid <= 1'b0;
		do begin
			@(posedge clock);
			guard(++n, 50);
		end while (rvalid !== 1'b1);
		last_rd = rdata;
		last_resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic wait_irq(input int b, input int lim);
		int n;
		n = 0;
		while (irqs[b] !== 1'b1) begin
			@(posedge clock);
			guard(++n, lim);
		end
	endtask
	task automatic count_irq(input int b, input int cyc);
		hits = 0;
		repeat (cyc) begin
			@(posedge clock);
			hits += int'(irqs[b] === 1'b1);
		end
	endtask
	task automatic wait_edges(input int k);
		int n;
		n = 0;
		while (int'(edges) < k) begin
			@(posedge clock);
			guard(++n, 6000);
		end
	endtask
	initial begin
		repeat (12) @(posedge clock);
		`CHK({pin_out, pin_oe_n, irqs, awready}, 5'b01001)
		arst_n <= 1'b1;
		foreach (rows[k]) begin
			if (rows[k].wr) begin
				wr(rows[k].idx, rows[k].wd);
				`CHK(last_resp, rows[k].wresp)
			end
			rd(rows[k].idx);
			`CHK({last_resp, last_rd}, {rows[k].rresp, 24'h0, rows[k].rd})
		end
		// Reload below 4095 and duty above reload, set before counting starts
		wr(IDX_PULSE_OUTPUT_CONTROL, 8'h01);
		wr(IDX_TIMER_CTRL_STATUS, 8'h12);
		wait_edges(3);
		`CHK({period, high, pin_oe_n}, {PER, HIGH, 1'b0})
		wait_irq(0, 40);
		`CHK({wake_wait, wake_active_halt}, 2'b10)
		wr(IDX_PULSE_CHANNEL_STATUS, 8'h02);
		// Polarity flip makes one partial pulse, so skip past it
		wait_edges(int'(edges) + 3);
		`CHK(high, PER - HIGH)
		rd(IDX_PULSE_CHANNEL_STATUS);
		`CHK(last_rd, 32'h3)
		halt <= 1'b1;
		rd(IDX_COUNTER_LOW);
		v1 = last_rd;
		repeat (20) @(posedge clock);
		rd(IDX_COUNTER_LOW);
		`CHK(last_rd, v1)
		halt <= 1'b0;
		wr(IDX_PULSE_OUTPUT_CONTROL, 8'h00);
		repeat (3) @(posedge clock);
		`CHK({pin_out, pin_oe_n}, {gpio_out, gpio_oe_n})
		wr(IDX_DUTY_HIGH, 8'h0f);
		wr(IDX_DUTY_LOW, 8'hf5);
		wr(IDX_TIMER_CTRL_STATUS, 8'h0b);
		tick_gap <= 20;
		rd(IDX_PULSE_CHANNEL_STATUS);
		wait_irq(1, 800);
		rd(IDX_PULSE_CHANNEL_STATUS);
		`CHK(last_rd, 32'h3)
		rd(IDX_PULSE_CHANNEL_STATUS);
		`CHK({last_rd, compare_irq}, {32'h2, 1'b0})
		wr(IDX_DUTY_HIGH, 8'h0f);
		count_irq(1, 400);
		`CHK(hits, 0)
		wr(IDX_DUTY_LOW, 8'hf5);
		wait_irq(1, 800);
		rd(IDX_TIMER_CTRL_STATUS);
		wait_irq(0, 800);
		`CHK(wake_active_halt, 1'b1)
		rd(IDX_TIMER_CTRL_STATUS);
		`CHK({last_rd, overflow_irq}, {32'h0f, 1'b0})
		tick_gap <= 0;
		wr(IDX_RELOAD_HIGH, 8'h00);
		wr(IDX_RELOAD_LOW, 8'h00);
		wr(IDX_DUTY_HIGH, 8'h00);
		wr(IDX_DUTY_LOW, 8'h00);
		wr(IDX_TIMER_CTRL_STATUS, 8'h11);
		rd(IDX_PULSE_CHANNEL_STATUS);
		count_irq(1, 4300);
		`CHK(hits, 0)
		// CPU clock without overflow interrupt must stop in active-halt
		ahalt <= 1'b1;
		rd(IDX_COUNTER_LOW);
		v1 = last_rd;
		repeat (20) @(posedge clock);
		rd(IDX_COUNTER_LOW);
		`CHK(last_rd, v1)
		ahalt <= 1'b0;
		slow <= 1'b1;
		rd(IDX_COUNTER_LOW);
		v1 = last_rd;
		// Samples land 64 clocks apart: exactly two slow steps
		repeat (2 * SLOW_DIV - 3) @(posedge clock);
		rd(IDX_COUNTER_LOW);
		`CHK(last_rd, {24'h0, 8'(v1[7:0] + 8'h02)})
		wrap_up();
	end
endmodule
`undef CHK
`default_nettype wire
